// ==== lim_pkg.sv ====
// Constants, field positions and bus carrier types for the link interrupt mask block.
package lim_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int          ADDR_W            = 8;
    localparam int          DATA_W            = 32;
    localparam int          PRIM_W            = 16;
    localparam int          NUM_TX_CTX        = 8;

    localparam logic [7:0]  OFF_MASK_SET      = 8'h88;
    localparam logic [7:0]  OFF_MASK_CLR      = 8'h8C;
    localparam logic [7:0]  OFF_TXEV_SET      = 8'h90;
    localparam logic [7:0]  OFF_TXEV_CLR      = 8'h94;

    localparam int          POS_GLOBAL_GATE   = 31;
    localparam int          POS_SELFID2       = 15;
    localparam int          POS_ATOMIC_ERR    = 9;
    localparam int          POS_BUF_WR_ERR    = 8;
    localparam int          POS_ISO_RX_SUM    = 7;
    localparam int          POS_ISO_TX_SUM    = 6;
    localparam int          POS_RSP_PKT       = 5;
    localparam int          POS_REQ_PKT       = 4;
    localparam int          POS_ARX_RSP       = 3;
    localparam int          POS_ARX_REQ       = 2;
    localparam int          POS_RSP_DONE      = 1;
    localparam int          POS_REQ_DONE      = 0;

    // Implemented enables; bits 14 to 10 are reserved and never store.
    localparam logic [15:0] MASK_LOW_IMPL     = 16'h83FF;
    localparam logic [15:0] MASK_LOW_RESET    = 16'h0000;
    localparam logic        GATE_RESET        = 1'b0;
    localparam logic [7:0]  TXEV_RESET        = 8'h00;
    localparam logic [1:0]  INT_CTL_ALWAYS    = 2'b11;

    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } lim_axil_req_type;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } lim_axil_rsp_type;

endpackage

// ==== lim_ctx_event.sv ====
// One transmit context event flag with edge-triggered set and software set and clear.
module lim_ctx_event (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       cmd_done,
    input  wire logic [1:0] int_ctl,
    input  wire logic       sw_set,
    input  wire logic       sw_clr,
    output logic            event_r
);

    logic int_prev_r;
    logic ctx_int;
    logic int_rise;

    // (RQ13) Completion with interrupt
    assign ctx_int  = cmd_done & (int_ctl == lim_pkg::INT_CTL_ALWAYS);
    // (RQ14) Rising edge sets
    assign int_rise = ctx_int & ~int_prev_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_prev_r <= 1'b0;
        end else if (ce) begin
            int_prev_r <= ctx_int;
        end
    end

    // A set arriving with a clear wins, so no completion is ever lost.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_r <= 1'b0;
        // (RQ14) Edge or write sets
        end else if (ce && (int_rise || sw_set)) begin
            event_r <= 1'b1;
        // (RQ15) Only clear write
        end else if (ce && sw_clr) begin
            event_r <= 1'b0;
        end
    end

endmodule // lim_ctx_event

// ==== lim_irq_mask.sv ====
// Primary interrupt enable mask, transmit context event register and AXI4-Lite slave.
//
// Implementation choice: the AXI4-Lite slave port.

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RQ1) Bit 15 interrupt needs mask bit 15 and event bit 15.
// (RQ2) Mask bits 14 to 10 are reserved and read as zero.
// (RQ3) Bit 9 atomic response error needs mask and event bit set.
// (RQ4) Bit 8 buffered write error needs mask and event bit set.
// (RQ5) Bit 7 receive summary needs mask and event bit set.
// (RQ6) Bit 6 transmit summary needs mask and event bit set.
// (RQ7) Bit 5 response packet received needs mask and event bit set.
// (RQ8) Bit 4 request packet received needs mask and event bit set.
// (RQ9) Bit 3 async receive response DMA needs mask and event bit.
// (RQ10) Bit 2 async receive request DMA needs mask and event bit.
// (RQ11) Bit 1 response send done needs mask and event bit set.
// (RQ12) Bit 0 request send done needs mask and event bit set.
// (RQ13) Context event rises on last-output completion with both interrupt bits one.
// (RQ14) Context bit sets on interrupt rising edge or set-alias write of one.
// (RQ15) Context bit clears only on clear-alias write of one.
// (RQ16) Clear-alias read returns events ANDed with transmit mask.
// (RQ17) Eight context bits 7..0; bit n flags context n behind bit 6.
// (RQ18) Event bits 31 to 8 read as zero.
// (RQ19) Event bits 31 to 8 reset to zero.
// (RQ20) No interrupt while global gate bit 31 is zero.
// (RQ21) Both mask aliases read the current mask.
// (RQ22) Interrupt is gated OR of masked events, updated within a clock.
module lim_irq_mask #(
    parameter int NUM_CTX = lim_pkg::NUM_TX_CTX
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    input  wire lim_pkg::lim_axil_req_type   axi_req,
    output lim_pkg::lim_axil_rsp_type        axi_rsp,
    input  wire logic [lim_pkg::PRIM_W-1:0]  primary_event,
    input  wire logic [NUM_CTX-1:0]          iso_tx_mask,
    input  wire logic [NUM_CTX-1:0]          tx_cmd_done,
    input  wire logic [2*NUM_CTX-1:0]        tx_int_ctl,
    output logic [NUM_CTX-1:0]               tx_event_r,
    output logic                             iso_tx_summary_r,
    output logic                             irq_r
);

    // The event word has eight slots, so more contexts could never be reported.
    if (NUM_CTX < 1 || NUM_CTX > 8) begin : g_bad_ctx
        $error("NUM_CTX must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus write path.
    logic                          aw_hold_r;
    logic [lim_pkg::ADDR_W-1:0]    awaddr_r;
    logic                          w_hold_r;
    logic [lim_pkg::DATA_W-1:0]    wdata_r;
    logic [3:0]                    wstrb_r;
    logic                          awready_r;
    logic                          wready_r;
    logic                          bvalid_r;
    logic [1:0]                    bresp_r;
    logic                          aw_fire;
    logic                          w_fire;
    logic                          b_fire;
    logic                          do_write;
    logic                          aw_hold_nxt;
    logic                          w_hold_nxt;
    logic                          bvalid_nxt;
    logic [lim_pkg::DATA_W-1:0]    wbits;

    assign aw_fire  = axi_req.awvalid & awready_r;
    assign w_fire   = axi_req.wvalid & wready_r;
    assign b_fire   = bvalid_r & axi_req.bready;
    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        bvalid_nxt  = bvalid_r;
        if (aw_fire) begin
            aw_hold_nxt = 1'b1;
        end else if (do_write) begin
            aw_hold_nxt = 1'b0;
        end
        if (w_fire) begin
            w_hold_nxt = 1'b1;
        end else if (do_write) begin
            w_hold_nxt = 1'b0;
        end
        if (do_write) begin
            bvalid_nxt = 1'b1;
        end else if (b_fire) begin
            bvalid_nxt = 1'b0;
        end
    end

    // Ready stays low while a beat is held or a response waits, so one write is in flight.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else if (ce) begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            bvalid_r  <= bvalid_nxt;
            awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
            wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= 4'h0;
        end else if (ce) begin
            if (aw_fire) begin
                awaddr_r <= axi_req.awaddr;
            end
            if (w_fire) begin
                wdata_r <= axi_req.wdata;
                wstrb_r <= axi_req.wstrb;
            end
        end
    end

    // Bytes whose strobe is low write nothing.
    always_comb begin
        wbits = '0;
        for (int i = 0; i < 4; i++) begin
            wbits[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8] : 8'h00;
        end
    end

    logic wr_mask_set;
    logic wr_mask_clr;
    logic wr_txev_set;
    logic wr_txev_clr;
    logic wr_mapped;

    assign wr_mask_set = do_write & (awaddr_r == lim_pkg::OFF_MASK_SET);
    assign wr_mask_clr = do_write & (awaddr_r == lim_pkg::OFF_MASK_CLR);
    assign wr_txev_set = do_write & (awaddr_r == lim_pkg::OFF_TXEV_SET);
    assign wr_txev_clr = do_write & (awaddr_r == lim_pkg::OFF_TXEV_CLR);
    assign wr_mapped   = wr_mask_set | wr_mask_clr | wr_txev_set | wr_txev_clr;

    // Unmapped writes are refused with an error but change no state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bresp_r <= lim_pkg::RESP_OKAY;
        end else if (ce && do_write) begin
            bresp_r <= wr_mapped ? lim_pkg::RESP_OKAY : lim_pkg::RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mask register, set and clear aliases.
    logic [15:0] mask_low_r;
    logic        global_gate_r;

    // (RQ2) Reserved bits never store
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_low_r <= lim_pkg::MASK_LOW_RESET;
        end else if (ce && wr_mask_set) begin
            mask_low_r <= mask_low_r | (wbits[15:0] & lim_pkg::MASK_LOW_IMPL);
        end else if (ce && wr_mask_clr) begin
            mask_low_r <= mask_low_r & ~(wbits[15:0] & lim_pkg::MASK_LOW_IMPL);
        end
    end

    // Bit 31 gates the whole output and is kept apart from the per-source enables.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            global_gate_r <= lim_pkg::GATE_RESET;
        end else if (ce && wr_mask_set && wbits[lim_pkg::POS_GLOBAL_GATE]) begin
            global_gate_r <= 1'b1;
        end else if (ce && wr_mask_clr && wbits[lim_pkg::POS_GLOBAL_GATE]) begin
            global_gate_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit context events.
    // (RQ17) One flag per context
    for (genvar n = 0; n < NUM_CTX; n++) begin : g_ctx
        lim_ctx_event u_ctx (
            .clk      (clk),
            .rstn     (rstn),
            .ce       (ce),
            .cmd_done (tx_cmd_done[n]),
            .int_ctl  (tx_int_ctl[2*n +: 2]),
            .sw_set   (wr_txev_set & wbits[n]),
            .sw_clr   (wr_txev_clr & wbits[n]),
            .event_r  (tx_event_r[n])
        );
    end

    // (RQ17) Summary of masked contexts
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            iso_tx_summary_r <= 1'b0;
        end else if (ce) begin
            iso_tx_summary_r <= |(tx_event_r & iso_tx_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt output.
    logic [15:0] event_vec;
    logic [15:0] masked_vec;

    // (RQ6) Own summary joins bit 6
    always_comb begin
        event_vec = primary_event;
        event_vec[lim_pkg::POS_ISO_TX_SUM] = primary_event[lim_pkg::POS_ISO_TX_SUM]
                                             | iso_tx_summary_r;
    end

    // Each enable is wired on its own so a reserved bit can never reach the OR.
    // (RQ1) Second self-id done
    assign masked_vec[lim_pkg::POS_SELFID2] =
        event_vec[lim_pkg::POS_SELFID2] & mask_low_r[lim_pkg::POS_SELFID2];
    // (RQ2) Reserved enables
    assign masked_vec[14:10] = 5'h00;
    // (RQ3) Atomic response error
    assign masked_vec[lim_pkg::POS_ATOMIC_ERR] =
        event_vec[lim_pkg::POS_ATOMIC_ERR] & mask_low_r[lim_pkg::POS_ATOMIC_ERR];
    // (RQ4) Buffered write error
    assign masked_vec[lim_pkg::POS_BUF_WR_ERR] =
        event_vec[lim_pkg::POS_BUF_WR_ERR] & mask_low_r[lim_pkg::POS_BUF_WR_ERR];
    // (RQ5) Receive summary
    assign masked_vec[lim_pkg::POS_ISO_RX_SUM] =
        event_vec[lim_pkg::POS_ISO_RX_SUM] & mask_low_r[lim_pkg::POS_ISO_RX_SUM];
    // (RQ6) Transmit summary
    assign masked_vec[lim_pkg::POS_ISO_TX_SUM] =
        event_vec[lim_pkg::POS_ISO_TX_SUM] & mask_low_r[lim_pkg::POS_ISO_TX_SUM];
    // (RQ7) Response packet received
    assign masked_vec[lim_pkg::POS_RSP_PKT] =
        event_vec[lim_pkg::POS_RSP_PKT] & mask_low_r[lim_pkg::POS_RSP_PKT];
    // (RQ8) Request packet received
    assign masked_vec[lim_pkg::POS_REQ_PKT] =
        event_vec[lim_pkg::POS_REQ_PKT] & mask_low_r[lim_pkg::POS_REQ_PKT];
    // (RQ9) Async response DMA
    assign masked_vec[lim_pkg::POS_ARX_RSP] =
        event_vec[lim_pkg::POS_ARX_RSP] & mask_low_r[lim_pkg::POS_ARX_RSP];
    // (RQ10) Async request DMA
    assign masked_vec[lim_pkg::POS_ARX_REQ] =
        event_vec[lim_pkg::POS_ARX_REQ] & mask_low_r[lim_pkg::POS_ARX_REQ];
    // (RQ11) Response send done
    assign masked_vec[lim_pkg::POS_RSP_DONE] =
        event_vec[lim_pkg::POS_RSP_DONE] & mask_low_r[lim_pkg::POS_RSP_DONE];
    // (RQ12) Request send done
    assign masked_vec[lim_pkg::POS_REQ_DONE] =
        event_vec[lim_pkg::POS_REQ_DONE] & mask_low_r[lim_pkg::POS_REQ_DONE];

    // The registered OR adds a cycle but keeps the pin free of glitches.
    // (RQ20) (RQ22) Gated OR output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= global_gate_r & (|masked_vec);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus read path.
    logic                       arready_r;
    logic                       rvalid_r;
    logic [lim_pkg::DATA_W-1:0] rdata_r;
    logic [1:0]                 rresp_r;
    logic                       ar_fire;
    logic [lim_pkg::DATA_W-1:0] rd_word;
    logic                       rd_hit;
    logic [7:0]                 ev_word;

    // Read data are captured when the address is taken and stand with rvalid.
    assign ar_fire = axi_req.arvalid & arready_r;

    // (RQ19) Upper bits held zero
    always_comb begin
        ev_word = 8'h00;
        ev_word[NUM_CTX-1:0] = tx_event_r;
    end

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (axi_req.araddr)
            // (RQ21) Both aliases read mask
            lim_pkg::OFF_MASK_SET, lim_pkg::OFF_MASK_CLR: begin
                rd_word[15:0] = mask_low_r & lim_pkg::MASK_LOW_IMPL;
                rd_word[lim_pkg::POS_GLOBAL_GATE] = global_gate_r;
            end
            // (RQ18) Upper bits zero
            lim_pkg::OFF_TXEV_SET: begin
                rd_word[7:0] = ev_word;
            end
            // (RQ16) Masked event read
            lim_pkg::OFF_TXEV_CLR: begin
                rd_word[NUM_CTX-1:0] = tx_event_r & iso_tx_mask;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= lim_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_word;
                rresp_r   <= rd_hit ? lim_pkg::RESP_OKAY : lim_pkg::RESP_SLVERR;
            end else if (rvalid_r && axi_req.rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end else if (!rvalid_r) begin
                arready_r <= 1'b1;
            end
        end
    end

    always_comb begin
        axi_rsp.awready = awready_r;
        axi_rsp.wready  = wready_r;
        axi_rsp.bvalid  = bvalid_r;
        axi_rsp.bresp   = bresp_r;
        axi_rsp.arready = arready_r;
        axi_rsp.rvalid  = rvalid_r;
        axi_rsp.rdata   = rdata_r;
        axi_rsp.rresp   = rresp_r;
    end

endmodule // lim_irq_mask

// ==== lim_irq_mask_checker.sv ====
// Port-level assertions for the link interrupt mask block.
module lim_checker #(
    parameter int NUM_CTX = 8
) (
    input wire logic                      clk,
    input wire logic                      rstn,
    input wire logic                      ce,
    input wire lim_pkg::lim_axil_req_type axi_req,
    input wire lim_pkg::lim_axil_rsp_type axi_rsp,
    input wire logic [15:0]               primary_event,
    input wire logic [NUM_CTX-1:0]        iso_tx_mask,
    input wire logic [NUM_CTX-1:0]        tx_cmd_done,
    input wire logic [2*NUM_CTX-1:0]      tx_int_ctl,
    input wire logic [NUM_CTX-1:0]        tx_event_r,
    input wire logic                      iso_tx_summary_r,
    input wire logic                      irq_r
);
    logic [NUM_CTX-1:0] int_now;
    logic [NUM_CTX-1:0] int_q_r;
    logic [7:0]         aw_q_r;
    logic [7:0]         ar_q_r;
    logic               gate_seen_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int i = 0; i < NUM_CTX; i++) begin
            int_now[i] = tx_cmd_done[i] && (tx_int_ctl[2*i +: 2] == 2'b11);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_q_r <= '0;
        end else if (ce) begin
            int_q_r <= int_now;
        end
    end

    // Addresses are latched because the master drops them once taken.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_q_r <= 8'h00;
            ar_q_r <= 8'h00;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) aw_q_r <= axi_req.awaddr;
            if (axi_req.arvalid && axi_rsp.arready) ar_q_r <= axi_req.araddr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gate_seen_r <= 1'b0;
        end else if (axi_rsp.bvalid && aw_q_r == lim_pkg::OFF_MASK_SET) begin
            gate_seen_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_event_edge_set: assert property (
        |(int_now & ~int_q_r) |=>
        ((tx_event_r & $past(int_now & ~int_q_r)) == $past(int_now & ~int_q_r)))
        else $error("context flag missed its rising interrupt");
    a_event_stays_set: assert property (
        |($past(tx_event_r) & ~tx_event_r) |->
        $rose(axi_rsp.bvalid) && aw_q_r == lim_pkg::OFF_TXEV_CLR)
        else $error("context flag fell without a clear write");
    a_summary_follows: assert property (
        iso_tx_summary_r == $past(|(tx_event_r & iso_tx_mask)))
        else $error("transmit summary does not follow masked flags");
    a_irq_needs_cause: assert property (
        irq_r |-> $past(primary_event != 16'h0000 || iso_tx_summary_r))
        else $error("interrupt without any event");
    a_gate_reset_quiet: assert property (
        !gate_seen_r |-> !irq_r)
        else $error("interrupt before the global gate was written");
    a_mask_rsv_zero: assert property (
        axi_rsp.rvalid && (ar_q_r == lim_pkg::OFF_MASK_SET || ar_q_r == lim_pkg::OFF_MASK_CLR)
        |-> axi_rsp.rdata[14:10] == 5'h00 && axi_rsp.rdata[30:16] == 15'h0000)
        else $error("reserved mask bits read nonzero");
    a_txev_rsv_zero: assert property (
        axi_rsp.rvalid && (ar_q_r == lim_pkg::OFF_TXEV_SET || ar_q_r == lim_pkg::OFF_TXEV_CLR)
        |-> axi_rsp.rdata[31:8] == 24'h000000)
        else $error("reserved event bits read nonzero");
    a_clr_read_and: assert property (
        $rose(axi_rsp.rvalid) && ar_q_r == lim_pkg::OFF_TXEV_CLR
        |-> axi_rsp.rdata[NUM_CTX-1:0] == $past(tx_event_r & iso_tx_mask))
        else $error("clear alias read is not flags and mask");

    c_irq_rise: cover property ($rose(irq_r));
    c_flag_clear: cover property (|($past(tx_event_r) & ~tx_event_r));
    c_read_error: cover property (axi_rsp.rvalid && axi_rsp.rresp == lim_pkg::RESP_SLVERR);
endmodule // lim_checker

bind lim_irq_mask lim_checker #(.NUM_CTX(NUM_CTX)) u_lim_checker (
    .clk(clk), .rstn(rstn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .primary_event(primary_event), .iso_tx_mask(iso_tx_mask), .tx_cmd_done(tx_cmd_done),
    .tx_int_ctl(tx_int_ctl), .tx_event_r(tx_event_r), .iso_tx_summary_r(iso_tx_summary_r),
    .irq_r(irq_r));

// ==== test_lim_irq_mask.sv ====
// Self-checking bench for the link interrupt mask block.
module test_lim_irq_mask;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      clk;
    logic                      rstn;
    logic                      ce;
    lim_pkg::lim_axil_req_type axi_req;
    lim_pkg::lim_axil_rsp_type axi_rsp;
    logic [15:0]               primary_event;
    logic [15:0]               tx_int_ctl;
    logic [7:0]                iso_tx_mask;
    logic [7:0]                tx_cmd_done;
    logic [7:0]                tx_event_r;
    logic                      iso_tx_summary_r;
    logic                      irq_r;
    int                        fail_count;
    int                        check_count;
    int                        cyc;
    logic [31:0]               rv;
    logic [1:0]                rs;

    lim_irq_mask #(.NUM_CTX(8)) DUT (
        .clk(clk), .rstn(rstn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .primary_event(primary_event), .iso_tx_mask(iso_tx_mask), .tx_cmd_done(tx_cmd_done),
        .tx_int_ctl(tx_int_ctl), .tx_event_r(tx_event_r),
        .iso_tx_summary_r(iso_tx_summary_r), .irq_r(irq_r));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Both channels are offered together; bready stays high throughout.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && axi_rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_ok && axi_rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (axi_rsp.bvalid !== 1'b1);
        rs = axi_rsp.bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        do @(posedge clk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        do @(posedge clk); while (axi_rsp.rvalid !== 1'b1);
        rv = axi_rsp.rdata;
        rs = axi_rsp.rresp;
    endtask

    task automatic irq_is(input logic exp);
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, irq_r}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_mask;
        int pos[11] = '{15, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
        rd(lim_pkg::OFF_MASK_CLR);
        chk("mask_reset", rv, 32'h0000_0000);
        wr(lim_pkg::OFF_MASK_SET, 32'hFFFF_FFFF);
        rd(lim_pkg::OFF_MASK_SET);
        chk("mask_set_read", rv, 32'h8000_83FF);
        rd(lim_pkg::OFF_MASK_CLR);
        chk("mask_clr_read", rv, 32'h8000_83FF);
        foreach (pos[i]) begin
            primary_event <= 16'h0001 << pos[i];
            wr(lim_pkg::OFF_MASK_CLR, 32'h0000_0001 << pos[i]);
            irq_is(1'b0);
            wr(lim_pkg::OFF_MASK_SET, 32'h0000_0001 << pos[i]);
            irq_is(1'b1);
        end
        wr(lim_pkg::OFF_MASK_CLR, 32'h8000_0000);
        irq_is(1'b0);
        wr(lim_pkg::OFF_MASK_SET, 32'h8000_0000);
        primary_event <= 16'h0000;
        irq_is(1'b0);
    endtask

    task automatic t_txev;
        rd(lim_pkg::OFF_TXEV_SET);
        chk("txev_reset", rv, 32'h0000_0000);
        iso_tx_mask <= 8'h0F;
        tx_int_ctl <= 16'hFFFF;
        tx_cmd_done <= 8'hA5;
        @(posedge clk);
        tx_cmd_done <= 8'h00;
        tx_int_ctl <= 16'h5555;
        @(posedge clk);
        tx_cmd_done <= 8'h5A;
        @(posedge clk);
        tx_cmd_done <= 8'h00;
        rd(lim_pkg::OFF_TXEV_SET);
        chk("txev_raw", rv, 32'h0000_00A5);
        rd(lim_pkg::OFF_TXEV_CLR);
        chk("txev_masked", rv, 32'h0000_0005);
        chk("txev_port", {24'h0, tx_event_r}, 32'h0000_00A5);
        chk("tx_summary", {31'h0, iso_tx_summary_r}, 32'h0000_0001);
        irq_is(1'b1);
        wr(lim_pkg::OFF_TXEV_CLR, 32'h0000_0000);
        rd(lim_pkg::OFF_TXEV_SET);
        chk("txev_clr_zero", rv, 32'h0000_00A5);
        wr(lim_pkg::OFF_TXEV_SET, 32'hFFFF_FF02);
        rd(lim_pkg::OFF_TXEV_SET);
        chk("txev_sw_set", rv, 32'h0000_00A7);
        tx_int_ctl <= 16'hFFFF;
        tx_cmd_done <= 8'h01;
        wr(lim_pkg::OFF_TXEV_CLR, 32'h0000_00FF);
        rd(lim_pkg::OFF_TXEV_SET);
        chk("txev_level_no_reset", rv, 32'h0000_0000);
        tx_cmd_done <= 8'h00;
        irq_is(1'b0);
    endtask

    task automatic t_freeze;
        ce <= 1'b0;
        primary_event <= 16'h0001;
        irq_is(1'b0);
        ce <= 1'b1;
        irq_is(1'b1);
        primary_event <= 16'h0000;
        irq_is(1'b0);
    endtask

    task automatic t_unmapped;
        wr(8'h40, 32'hFFFF_FFFF);
        chk("wr_resp", {30'h0, rs}, {30'h0, lim_pkg::RESP_SLVERR});
        rd(8'h40);
        chk("rd_resp", {30'h0, rs}, {30'h0, lim_pkg::RESP_SLVERR});
        chk("rd_data", rv, 32'h0000_0000);
        rd(lim_pkg::OFF_MASK_SET);
        chk("mask_kept", rv, 32'h8000_83FF);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        fail_count = 0;
        check_count = 0;
        cyc = 0;
        rstn = 1'b0;
        ce = 1'b1;
        axi_req = '0;
        axi_req.wstrb = 4'hF;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        primary_event = 16'h0000;
        iso_tx_mask = 8'h00;
        tx_cmd_done = 8'h00;
        tx_int_ctl = 16'h0000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_mask();
        t_txev();
        t_freeze();
        t_unmapped();
        stop_test();
    end
endmodule // test_lim_irq_mask
